/* include/usb_err_ctrl_pkg.sv */
/*
 * Constants shared by the USB error-interrupt and control block:
 * register offsets, field positions, reset values and timing.
 * Assumes a 25 MHz system clock and a plain strobe register port.
 */
package usb_err_ctrl_pkg;

    // Register bus geometry
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;

    // Register byte offsets
    localparam logic [7:0]  OFS_ERR_ENABLE  = 8'h00;
    localparam logic [7:0]  OFS_CONTROL     = 8'h04;
    localparam logic [7:0]  OFS_ADDRESS     = 8'h08;
    localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h0c;
    localparam logic [7:0]  OFS_ERR_FLAGS   = 8'h10;
    localparam logic [7:0]  OFS_TOKEN       = 8'h14;

    // Error enable / flag bit positions
    localparam int          ERR_PID         = 0;
    localparam int          ERR_CRC5_EOF    = 1;
    localparam int          ERR_CRC16       = 2;
    localparam int          ERR_FIELD_SIZE  = 3;
    localparam int          ERR_TURNAROUND  = 4;
    localparam int          ERR_DMA         = 5;
    localparam int          ERR_BUS_MATRIX  = 6;
    localparam int          ERR_BIT_STUFF   = 7;
    localparam int          ERR_COUNT       = 8;

    // Control register fields
    localparam int          CTL_ENABLE      = 0;
    localparam int          CTL_PP_RESET    = 1;
    localparam int          CTL_RESUME      = 2;
    localparam int          CTL_HOST_MODE   = 3;
    localparam int          CTL_TOKEN_BUSY  = 5;

    // Main interrupt enable field
    localparam int          IE_ERROR        = 1;

    // Address register fields
    localparam int          ADR_LOW_SPEED   = 7;
    localparam int          ADR_FUNC_W      = 7;

    // Reset values
    localparam logic [7:0]  RST_BYTE        = 8'h00;

    // Frame timing
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          SOF_PERIOD_US   = 1000;
    localparam int          SOF_CYCLES      = CLK_HZ / 1_000_000 * SOF_PERIOD_US;

endpackage : usb_err_ctrl_pkg

/* hw/usb_err_flag_bit.sv */
/*
 * One sticky error flag with its interrupt enable gate.
 * Assumes the event is a same-clock pulse and the clear a write-one strobe.
 */
`timescale 1ns/1ps
module usb_err_flag_bit (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic event_in,
    input  wire logic clear_in,
    input  wire logic enable_in,
    output logic      flag,
    output logic      gated
);

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (event_in) begin
            flag <= 1'b1;
        end else if (clear_in) begin
            flag <= 1'b0;
        end
    end

    // Flag reaches the error request only when enabled
    assign gated = flag & enable_in;

endmodule : usb_err_flag_bit

/* hw/usb_period_timer.sv */
/*
 * Free counter that pulses once per PERIOD cycles while enabled.
 * Assumes a synchronous active-low reset; restart clears the count.
 */
`timescale 1ns/1ps
module usb_period_timer #(
    parameter int PERIOD = 25000
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic run,
    input  wire logic restart,
    output logic      tick
);

    localparam int CW = $clog2(PERIOD);

    logic [CW-1:0] count;
    logic          at_end;

    // Terminal count of the period
    assign at_end = (count == CW'(PERIOD - 1));

    // Count while running, hold at zero otherwise
    always_ff @(posedge clk) begin
        if (!nrst || !run || restart) begin
            count <= '0;
        end else if (at_end) begin
            count <= '0;
        end else begin
            count <= count + CW'(1);
        end
    end

    // One-cycle pulse at the end of each period
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tick <= 1'b0;
        end else begin
            tick <= run & ~restart & at_end;
        end
    end

endmodule : usb_period_timer

/* hw/usb_error_irq_and_control.sv */
/*
 * USB error-interrupt enable bank, control register and function address
 * register, with the error flag bank, start-of-frame timer, token busy
 * tracking, host reset on mode change and resume end-of-packet request.
 * Assumes the USB engine supplies one-cycle error events and a token-done
 * pulse on clk, and software uses the strobe register port.
 */
`timescale 1ns/1ps
module usb_error_irq_and_control #(
    parameter int SOF_PERIOD = usb_err_ctrl_pkg::SOF_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Error events and token completion from the USB engine
    input  wire logic [7:0]  err_event,
    input  wire logic        eof_err_event,
    input  wire logic        token_done,
    // Outputs to the USB engine
    output logic             usb_irq_flag,
    output logic             error_irq_req,
    output logic             module_power_enable,
    output logic             host_mode,
    output logic             pingpong_pointer_reset,
    output logic             host_logic_reset,
    output logic             sof_send,
    output logic             resume_drive,
    output logic             resume_eop_low_speed,
    output logic             low_speed_next_token,
    output logic [6:0]       function_address,
    output logic             token_start,
    output logic [7:0]       token_command,
    output logic             token_busy
);

    // Software-visible state and the enable-gated flag bits
    logic [7:0] err_enable;
    logic [7:0] control;
    logic [7:0] address;
    logic [7:0] irq_enable;
    logic [7:0] err_flags;
    logic [7:0] err_gated;

    // Change detection history
    logic       host_mode_q;
    logic       resume_q;

    // Address decode
    wire hit_err_en  = (reg_addr == usb_err_ctrl_pkg::OFS_ERR_ENABLE);
    wire hit_control = (reg_addr == usb_err_ctrl_pkg::OFS_CONTROL);
    wire hit_address = (reg_addr == usb_err_ctrl_pkg::OFS_ADDRESS);
    wire hit_irq_en  = (reg_addr == usb_err_ctrl_pkg::OFS_IRQ_ENABLE);
    wire hit_flags   = (reg_addr == usb_err_ctrl_pkg::OFS_ERR_FLAGS);
    wire hit_token   = (reg_addr == usb_err_ctrl_pkg::OFS_TOKEN);

    // Write strobes per register
    wire wr_err_en   = reg_wr & hit_err_en;
    wire wr_control  = reg_wr & hit_control;
    wire wr_address  = reg_wr & hit_address;
    wire wr_irq_en   = reg_wr & hit_irq_en;
    wire wr_flags    = reg_wr & hit_flags;
    wire wr_token    = reg_wr & hit_token;

    // Mode derived from the host enable bit
    wire host_now    = control[usb_err_ctrl_pkg::CTL_HOST_MODE];
    wire resume_now  = control[usb_err_ctrl_pkg::CTL_RESUME];

    // Error enable register, only the low byte is stored
    always_ff @(posedge clk) begin
        if (!nrst) begin
            err_enable <= usb_err_ctrl_pkg::RST_BYTE;
        end else if (wr_err_en) begin
            err_enable <= reg_wdata[7:0];
        end
    end

    // Written control byte; the token busy position is not software writable
    logic [7:0] next_control;
    always_comb begin
        next_control = reg_wdata[7:0];
        next_control[usb_err_ctrl_pkg::CTL_TOKEN_BUSY] = 1'b0;
    end

    // Control register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            control <= usb_err_ctrl_pkg::RST_BYTE;
        end else if (wr_control) begin
            control <= next_control;
        end
    end

    // Function address register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            address <= usb_err_ctrl_pkg::RST_BYTE;
        end else if (wr_address) begin
            address <= reg_wdata[7:0];
        end
    end

    // Main interrupt enable register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_enable <= usb_err_ctrl_pkg::RST_BYTE;
        end else if (wr_irq_en) begin
            irq_enable <= reg_wdata[7:0];
        end
    end

    // Flag bit 1 source follows the operating mode
    logic [7:0] flag_src;
    always_comb begin
        flag_src = err_event;
        flag_src[usb_err_ctrl_pkg::ERR_CRC5_EOF] = host_now ? eof_err_event
                                                 : err_event[usb_err_ctrl_pkg::ERR_CRC5_EOF];
    end

    // Write-one-to-clear strobes for the flag bank
    wire [7:0] flag_clear = {8{wr_flags}} & reg_wdata[7:0];

    // Sticky flags, each gated by its enable bit
    genvar gi;
    generate
        for (gi = 0; gi < usb_err_ctrl_pkg::ERR_COUNT; gi++) begin : g_flag
            usb_err_flag_bit u_flag (
                .clk       (clk),
                .nrst      (nrst),
                .event_in  (flag_src[gi]),
                .clear_in  (flag_clear[gi]),
                .enable_in (err_enable[gi]),
                .flag      (err_flags[gi]),
                .gated     (err_gated[gi])
            );
        end
    endgenerate

    // Aggregated error request and its path to the USB interrupt flag
    assign error_irq_req = |err_gated;
    wire   next_irq_flag = error_irq_req & irq_enable[usb_err_ctrl_pkg::IE_ERROR];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            usb_irq_flag <= 1'b0;
        end else begin
            usb_irq_flag <= next_irq_flag;
        end
    end

    // Previous host enable value for change detection
    always_ff @(posedge clk) begin
        if (!nrst) begin
            host_mode_q <= 1'b0;
        end else begin
            host_mode_q <= host_now;
        end
    end

    // Previous resume value for the falling-edge request
    always_ff @(posedge clk) begin
        if (!nrst) begin
            resume_q <= 1'b0;
        end else begin
            resume_q <= resume_now;
        end
    end

    // Host reset on either edge of the host enable bit
    wire host_toggle = host_now ^ host_mode_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            host_logic_reset <= 1'b0;
        end else begin
            host_logic_reset <= host_toggle;
        end
    end

    // Low-speed end-of-packet request when resume drops in host mode
    wire next_eop = host_now & resume_q & ~resume_now;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            resume_eop_low_speed <= 1'b0;
        end else begin
            resume_eop_low_speed <= next_eop;
        end
    end

    // Resume line follows the bit; software times its length
    always_ff @(posedge clk) begin
        if (!nrst) begin
            resume_drive <= 1'b0;
        end else begin
            resume_drive <= resume_now;
        end
    end

    // Bit 0 is module power in device mode, frame start in host mode
    wire sof_run    = host_now & control[usb_err_ctrl_pkg::CTL_ENABLE];
    wire next_power = ~host_now & control[usb_err_ctrl_pkg::CTL_ENABLE];

    // Module power only in device mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            module_power_enable <= 1'b0;
        end else begin
            module_power_enable <= next_power;
        end
    end

    // Registered copy of the operating mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            host_mode <= 1'b0;
        end else begin
            host_mode <= host_now;
        end
    end

    // Start-of-frame every millisecond, restarted by a host reset
    usb_period_timer #(
        .PERIOD (SOF_PERIOD)
    ) u_sof (
        .clk     (clk),
        .nrst    (nrst),
        .run     (sof_run),
        .restart (host_toggle),
        .tick    (sof_send)
    );

    // Buffer pointers held at the even bank while the bit is set
    wire next_pp_reset = control[usb_err_ctrl_pkg::CTL_PP_RESET];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pingpong_pointer_reset <= 1'b0;
        end else begin
            pingpong_pointer_reset <= next_pp_reset;
        end
    end

    // Speed for the next token
    always_ff @(posedge clk) begin
        if (!nrst) begin
            low_speed_next_token <= 1'b0;
        end else begin
            low_speed_next_token <= address[usb_err_ctrl_pkg::ADR_LOW_SPEED];
        end
    end

    // Function address used on the bus
    always_ff @(posedge clk) begin
        if (!nrst) begin
            function_address <= 7'h00;
        end else begin
            function_address <= address[usb_err_ctrl_pkg::ADR_FUNC_W-1:0];
        end
    end

    // Token command: accepted only when idle, busy until done
    wire token_take = wr_token & ~token_busy;

    // Busy from an accepted command until the engine reports done
    always_ff @(posedge clk) begin
        if (!nrst) begin
            token_busy <= 1'b0;
        end else if (token_take) begin
            token_busy <= 1'b1;
        end else if (token_done) begin
            token_busy <= 1'b0;
        end
    end

    // Start pulse one cycle after an accepted command
    always_ff @(posedge clk) begin
        if (!nrst) begin
            token_start <= 1'b0;
        end else begin
            token_start <= token_take;
        end
    end

    // Last accepted token command byte
    always_ff @(posedge clk) begin
        if (!nrst) begin
            token_command <= 8'h00;
        end else if (token_take) begin
            token_command <= reg_wdata[7:0];
        end
    end

    // Control readback with live token busy status
    logic [7:0] control_view;
    always_comb begin
        control_view = control;
        control_view[usb_err_ctrl_pkg::CTL_TOKEN_BUSY] = token_busy;
    end

    // Read mux; upper bits and unmapped addresses read zero
    wire [7:0] rd_byte = hit_err_en  ? err_enable   :
                         hit_control ? control_view :
                         hit_address ? address      :
                         hit_irq_en  ? irq_enable   :
                         hit_flags   ? err_flags    :
                         hit_token   ? token_command :
                                       8'h00;

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= {24'h00_0000, rd_byte};
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule : usb_error_irq_and_control

/* verif/usb_err_ctrl_properties.sv */
/* Port checker for the USB error-interrupt and control block.
   Bound to the top module; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module usb_err_ctrl_properties #(
    parameter int SOF_PERIOD = 25000
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [7:0]  err_event,
    input wire logic        eof_err_event,
    input wire logic        usb_irq_flag,
    input wire logic        error_irq_req,
    input wire logic        module_power_enable,
    input wire logic        host_mode,
    input wire logic        pingpong_pointer_reset,
    input wire logic        host_logic_reset,
    input wire logic        sof_send,
    input wire logic        resume_drive,
    input wire logic        resume_eop_low_speed,
    input wire logic        low_speed_next_token,
    input wire logic [6:0]  function_address,
    input wire logic        token_start,
    input wire logic [7:0]  token_command,
    input wire logic        token_busy
);
    logic [31:0] gap;
    logic        gap_ok;
    logic [2:0]  ctl_hist;
    // Decoded register accesses
    wire ctl_wr = reg_wr && reg_addr == usb_err_ctrl_pkg::OFS_CONTROL;
    wire adr_wr = reg_wr && reg_addr == usb_err_ctrl_pkg::OFS_ADDRESS;
    wire tok_wr = reg_wr && reg_addr == usb_err_ctrl_pkg::OFS_TOKEN;
    wire ena_rd = reg_rd && reg_addr == usb_err_ctrl_pkg::OFS_ERR_ENABLE;
    // Frame-start spacing, invalid just after control writes
    always_ff @(posedge clk) begin
        gap      <= (!nrst || sof_send) ? 32'h0 : gap + 32'h1;
        ctl_hist <= nrst ? {ctl_hist[1:0], ctl_wr} : 3'h0;
        if (!nrst || !host_mode || ctl_wr || (|ctl_hist)) begin
            gap_ok <= 1'b0;
        end else if (sof_send) begin
            gap_ok <= 1'b1;
        end
    end
    sequence tok_take;
        tok_wr && !token_busy;
    endsequence
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    irq_gate_a: assert property (usb_irq_flag |-> $past(error_irq_req))
        else $error("usb irq flag without error request");
    req_cause_a: assert property ($rose(error_irq_req) |-> $past(|err_event || eof_err_event || reg_wr))
        else $error("error request rose without a cause");
    upper_zero_a: assert property ($past(ena_rd) |-> reg_rdata[31:8] == 24'h0)
        else $error("enable register upper bits not zero");
    addr_field_a: assert property ($past(adr_wr, 2) |->
        {low_speed_next_token, function_address} == $past(reg_wdata[7:0], 2))
        else $error("address outputs differ from written value");
    pp_reset_a: assert property ($past(ctl_wr, 2) |-> pingpong_pointer_reset == $past(reg_wdata[1], 2))
        else $error("pingpong reset differs from control bit");
    power_mode_a: assert property ($past(ctl_wr, 2) |->
        module_power_enable == ($past(reg_wdata[0], 2) && !$past(reg_wdata[3], 2)))
        else $error("module power differs from control bits");
    host_reset_a: assert property ($changed(host_mode) |-> ##[0:1] host_logic_reset)
        else $error("no host reset on mode change");
    sof_host_a: assert property (sof_send |-> host_mode)
        else $error("frame start outside host mode");
    sof_gap_a: assert property (sof_send && gap_ok |-> gap == SOF_PERIOD - 1)
        else $error("frame start spacing wrong");
    eop_tail_a: assert property ($fell(resume_drive) && host_mode |-> ##[0:1] resume_eop_low_speed)
        else $error("no end of packet after resume in host mode");
    token_take_a: assert property (tok_take |=> token_start && token_busy && token_command == $past(reg_wdata[7:0]))
        else $error("token command not taken");
    token_hold_a: assert property (tok_wr && token_busy |=> !token_start && $stable(token_command))
        else $error("token taken while busy");
endmodule : usb_err_ctrl_properties

bind usb_error_irq_and_control usb_err_ctrl_properties #(.SOF_PERIOD(SOF_PERIOD)) chk (.clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .err_event, .eof_err_event, .usb_irq_flag, .error_irq_req,
    .module_power_enable, .host_mode, .pingpong_pointer_reset, .host_logic_reset, .sof_send, .resume_drive,
    .resume_eop_low_speed, .low_speed_next_token, .function_address, .token_start, .token_command, .token_busy);

/* verif/usb_engine_model.sv */
/* Model of the USB engine beside the block: error event pulses and
   token completion, prompt or slow. Runs on the block's clock. */
`timescale 1ns/1ps
module usb_engine_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] fire,
    input  wire logic       fire_eof,
    input  wire logic       slow,
    input  wire logic       token_start,
    output logic      [7:0] err_event,
    output logic            eof_err_event,
    output logic            token_done
);
    logic [3:0] left;
    // One-cycle error pulses and token completion countdown
    always_ff @(posedge clk) begin
        err_event     <= nrst ? fire : 8'h00;
        eof_err_event <= nrst && fire_eof;
        token_done    <= nrst && left == 4'h1;
        if (!nrst) begin
            left <= 4'h0;
        end else if (token_start) begin
            left <= slow ? 4'h8 : 4'h1;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
endmodule : usb_engine_model

/* verif/test_usb_error_irq_and_control.sv */
/* Self-checking bench for the USB error-interrupt and control block.
   Drives the strobe register port and an engine model; 25 MHz clock. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module test_usb_error_irq_and_control;
    localparam int SOFP = 20;
    logic        clk, nrst, reg_wr, reg_rd, fire_eof, slow, token_done, eof_err_event;
    logic [7:0]  reg_addr, fire, err_event, token_command;
    logic [31:0] reg_wdata, reg_rdata;
    logic        usb_irq_flag, error_irq_req, module_power_enable, host_mode, pingpong_pointer_reset;
    logic        host_logic_reset, sof_send, resume_drive, resume_eop_low_speed, low_speed_next_token;
    logic        token_start, token_busy;
    logic [6:0]  function_address;
    logic [7:0]  av [2] = '{8'h8a, 8'h7f};
    int          n_mismatch, n_checks, n_sof, n_eop, n_hrst, cycles, c0;

    usb_error_irq_and_control #(.SOF_PERIOD(SOFP)) uut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .err_event, .eof_err_event, .token_done, .usb_irq_flag, .error_irq_req, .module_power_enable,
        .host_mode, .pingpong_pointer_reset, .host_logic_reset, .sof_send, .resume_drive, .resume_eop_low_speed,
        .low_speed_next_token, .function_address, .token_start, .token_command, .token_busy);
    usb_engine_model eng (.clk, .nrst, .fire, .fire_eof, .slow, .token_start, .err_event, .eof_err_event,
        .token_done);

    always #20 clk = ~clk;

    // Pulse counters and run ceiling
    always @(posedge clk) begin
        n_sof += (sof_send === 1'b1);
        n_eop += (resume_eop_low_speed === 1'b1);
        n_hrst += (host_logic_reset === 1'b1);
        cycles++;
        if (cycles > 5000) begin
            n_mismatch++;
            test_done;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("read data", ex, reg_rdata)
    endtask : rd

    task automatic pulse_err(input logic [7:0] e, input logic eof);
        @(posedge clk);
        fire     <= e;
        fire_eof <= eof;
        @(posedge clk);
        fire     <= 8'h00;
        fire_eof <= 1'b0;
    endtask : pulse_err

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task automatic test_done;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        {clk, nrst, reg_wr, reg_rd, fire_eof, slow, fire, reg_addr, reg_wdata} = '0;
        {n_mismatch, n_checks, n_sof, n_eop, n_hrst, cycles} = '0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
        wr(usb_err_ctrl_pkg::OFS_ERR_ENABLE, 32'hffffffff);
        rd(usb_err_ctrl_pkg::OFS_ERR_ENABLE, 32'h000000ff);
        wr(usb_err_ctrl_pkg::OFS_IRQ_ENABLE, 32'h2);
        for (int i = 0; i < 8; i++) begin
            wr(usb_err_ctrl_pkg::OFS_ERR_ENABLE, 32'(1 << i));
            pulse_err(8'(~(1 << i)), 1'b1);
            settle;
            `CHK("masked request", 1'b0, error_irq_req)
            pulse_err(8'(1 << i), 1'b0);
            settle;
            `CHK("request", 1'b1, error_irq_req)
            `CHK("irq flag", 1'b1, usb_irq_flag)
            wr(usb_err_ctrl_pkg::OFS_ERR_FLAGS, 32'hff);
        end
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h8);
        wr(usb_err_ctrl_pkg::OFS_ERR_ENABLE, 32'h2);
        pulse_err(8'h02, 1'b0);
        settle;
        `CHK("host crc5 request", 1'b0, error_irq_req)
        pulse_err(8'h00, 1'b1);
        settle;
        `CHK("host eof request", 1'b1, error_irq_req)
        wr(usb_err_ctrl_pkg::OFS_ERR_FLAGS, 32'hff);
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h0);
        wr(usb_err_ctrl_pkg::OFS_IRQ_ENABLE, 32'h0);
        wr(usb_err_ctrl_pkg::OFS_ERR_ENABLE, 32'h1);
        pulse_err(8'h01, 1'b0);
        settle;
        `CHK("request", 1'b1, error_irq_req)
        `CHK("irq flag off", 1'b0, usb_irq_flag)
        wr(usb_err_ctrl_pkg::OFS_IRQ_ENABLE, 32'h2);
        settle;
        `CHK("irq flag on", 1'b1, usb_irq_flag)
        wr(usb_err_ctrl_pkg::OFS_ERR_FLAGS, 32'h1);
        settle;
        `CHK("cleared request", 1'b0, error_irq_req)
        foreach (av[k]) begin
            wr(usb_err_ctrl_pkg::OFS_ADDRESS, {24'h0, av[k]});
            settle;
            `CHK("address", av[k], {low_speed_next_token, function_address})
            rd(usb_err_ctrl_pkg::OFS_ADDRESS, {24'h0, av[k]});
        end
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h3);
        settle;
        `CHK("power", 1'b1, module_power_enable)
        `CHK("pingpong", 1'b1, pingpong_pointer_reset)
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h0);
        settle;
        `CHK("power", 1'b0, module_power_enable)
        `CHK("pingpong", 1'b0, pingpong_pointer_reset)
        n_hrst = 0;
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h9);
        settle;
        `CHK("host power", 1'b0, module_power_enable)
        c0 = n_sof;
        repeat (5 * SOFP) @(posedge clk);
        `CHK("frame starts", 5, n_sof - c0)
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h8);
        settle;
        c0 = n_sof;
        repeat (2 * SOFP) @(posedge clk);
        `CHK("frame starts off", 0, n_sof - c0)
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'hc);
        settle;
        `CHK("resume", 1'b1, resume_drive)
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h8);
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h0);
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h4);
        wr(usb_err_ctrl_pkg::OFS_CONTROL, 32'h0);
        settle;
        `CHK("eop count", 1, n_eop)
        `CHK("host resets", 2, n_hrst)
        slow <= 1'b1;
        wr(usb_err_ctrl_pkg::OFS_TOKEN, 32'h5a);
        settle;
        `CHK("busy", 1'b1, token_busy)
        wr(usb_err_ctrl_pkg::OFS_TOKEN, 32'h33);
        settle;
        `CHK("token kept", 8'h5a, token_command)
        for (int k = 0; k < 20 && token_busy === 1'b1; k++) @(posedge clk);
        #1;
        `CHK("busy done", 1'b0, token_busy)
        slow <= 1'b0;
        wr(usb_err_ctrl_pkg::OFS_TOKEN, 32'h33);
        settle;
        repeat (2) @(posedge clk);
        #1;
        `CHK("token", 8'h33, token_command)
        `CHK("prompt done", 1'b0, token_busy)
        test_done;
    end
endmodule : test_usb_error_irq_and_control
